// [rate_gen_dio_autocal_ctrl.v]
// Rate generators, digital port, autocalibration handshake and lamp control
//
// Contract
// - Two generators: sample clock and burst trigger.
// - Generator runs only while its enable set.
// - 24-bit divisor, upper byte reads zero.
// - Offsets 4Ch/50h, resets 200h and 3000h.
// - Output rate is clock over divisor.
// - Eight lines in two independently directed nibbles.
// - Direction bits D07, D15; high drives.
// - Bits 0-3, 8-11 map to lines uninverted.
// - Same polarity reading and writing.
// - Both nibbles come up as inputs.
// - Upper half reads zero; reserved reset zero.
// - Start bit begins calibration, self-clears at end.
// - Calibration lasts about seven, under ten seconds.
// - Completion event signalled in status.
// - Cal-done response D16, selected D00, sticky.
// - Correction values held in volatile storage.
// - Failure drops pass bit until next run.
// - Pass bit high from reset unless failure.
// - Analog outputs stay active during calibration.
// - Lamp follows its bit; resets on.
`timescale 1ns/1ns
`default_nettype none
`include "rate_dio_consts.vh"
module rate_gen_dio_autocal_ctrl #(
  parameter DIV_WIDTH = 24,
  parameter CAL_CYCLES = `CAL_CYCLES,
  parameter CORR_WORDS = 16
) (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Local register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  // Generator outputs
  output wire sample_clock_tick,
  output wire burst_trigger_tick,
  // Digital port pins
  input wire [7:0] aux_port_line_in,
  output reg [7:0] aux_port_line_out,
  output reg [7:0] aux_port_line_oe,
  // Calibration engine
  input wire cal_engine_fail,
  input wire cal_corr_valid,
  input wire [3:0] cal_corr_index,
  input wire [15:0] cal_corr_value,
  output reg cal_running,
  output wire analog_outputs_active,
  // Front panel
  output reg indicator_lamp_on
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CAL = 2'b10;
  localparam CNT_W = 40;

  reg [DIV_WIDTH-1:0] sample_rate_divisor;
  reg [DIV_WIDTH-1:0] trigger_rate_divisor;
  reg rate_a_en;
  reg rate_b_en;
  reg restart_a;
  reg restart_b;
  reg cal_pass;
  reg [1:0] state;
  reg [CNT_W-1:0] cal_count;
  reg cal_done_sel;
  reg cal_done_rsp;
  reg cal_end;
  reg low_nibble_drive;
  reg high_nibble_drive;
  reg [2:0] rsv_lo;
  reg [2:0] rsv_hi;
  reg [7:0] port_out;
  reg [7:0] sync1;
  reg [7:0] sync2;
  reg [7:0] sync3;
  reg [7:0] port_in;
  reg [15:0] corr_mem [0:CORR_WORDS-1];
  wire wr_ctrl;
  wire wr_port;
  wire wr_stat;
  wire [31:0] ctrl_view;
  integer i;

  assign wr_ctrl = reg_wr && (reg_addr == `OFS_CTRL);
  assign wr_port = reg_wr && (reg_addr == `OFS_PORT);
  assign wr_stat = reg_wr && (reg_addr == `OFS_STATUS);
  assign analog_outputs_active = 1'b1;

  // Generators
  rate_divider #(.WIDTH(DIV_WIDTH)) u_rate_a (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .enable(rate_a_en),
    .restart(restart_a),
    .divisor(sample_rate_divisor),
    .tick(sample_clock_tick)
  );
  rate_divider #(.WIDTH(DIV_WIDTH)) u_rate_b (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .enable(rate_b_en),
    .restart(restart_b),
    .divisor(trigger_rate_divisor),
    .tick(burst_trigger_tick)
  );

  always @(posedge sys_clk) begin
    if (!resetn) begin
      sample_rate_divisor <= `RATE_A_RESET;
      trigger_rate_divisor <= `RATE_B_RESET;
      rate_a_en <= 1'b0;
      rate_b_en <= 1'b0;
      restart_a <= 1'b0;
      restart_b <= 1'b0;
      indicator_lamp_on <= 1'b1;
    end else begin
      restart_a <= reg_wr && (reg_addr == `OFS_RATE_A);
      restart_b <= reg_wr && (reg_addr == `OFS_RATE_B);
      if (reg_wr && reg_addr == `OFS_RATE_A)
        sample_rate_divisor <= reg_wdata[DIV_WIDTH-1:0];
      if (reg_wr && reg_addr == `OFS_RATE_B)
        trigger_rate_divisor <= reg_wdata[DIV_WIDTH-1:0];
      if (wr_ctrl) begin
        rate_a_en <= reg_wdata[`CTRL_RATE_A_EN];
        rate_b_en <= reg_wdata[`CTRL_RATE_B_EN];
        indicator_lamp_on <= reg_wdata[`CTRL_LAMP];
      end
    end
  end

  // Calibration sequencer; duration is the typical figure, inside the maximum
  always @(posedge sys_clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      cal_running <= 1'b0;
      cal_count <= {CNT_W{1'b0}};
      cal_pass <= 1'b1;
      cal_end <= 1'b0;
    end else begin
      cal_end <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (wr_ctrl && reg_wdata[`CTRL_AUTOCAL]) begin
            state <= ST_CAL;
            cal_running <= 1'b1;
            cal_count <= {CNT_W{1'b0}};
            cal_pass <= 1'b1;
          end
        end
        ST_CAL: begin
          if (cal_engine_fail)
            cal_pass <= 1'b0;
          if (cal_count >= CAL_CYCLES - 1) begin
            state <= ST_IDLE;
            cal_running <= 1'b0;
            cal_end <= 1'b1;
          end else begin
            cal_count <= cal_count + 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          cal_running <= 1'b0;
        end
      endcase
    end
  end

  // Correction values, volatile
  always @(posedge sys_clk) begin
    if (cal_running && cal_corr_valid)
      corr_mem[cal_corr_index] <= cal_corr_value;
  end

  // Status: sticky response, set beats clear
  always @(posedge sys_clk) begin
    if (!resetn) begin
      cal_done_sel <= 1'b0;
      cal_done_rsp <= 1'b0;
    end else begin
      if (wr_stat)
        cal_done_sel <= reg_wdata[`STAT_CAL_SEL];
      if (cal_end && cal_done_sel)
        cal_done_rsp <= 1'b1;
      else if (wr_stat && (!reg_wdata[`STAT_CAL_RSP] || !reg_wdata[`STAT_CAL_SEL]))
        cal_done_rsp <= 1'b0;
    end
  end

  // Digital port
  always @(posedge sys_clk) begin
    if (!resetn) begin
      low_nibble_drive <= 1'b0;
      high_nibble_drive <= 1'b0;
      rsv_lo <= 3'h0;
      rsv_hi <= 3'h0;
      port_out <= 8'h00;
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
      port_in <= 8'h00;
      aux_port_line_out <= 8'h00;
      aux_port_line_oe <= 8'h00;
    end else begin
      sync1 <= aux_port_line_in;
      sync2 <= sync1;
      sync3 <= sync2;
      for (i = 0; i < 8; i = i + 1) begin
        if (sync2[i] == sync3[i])
          port_in[i] <= sync3[i];
      end
      if (wr_port) begin
        port_out <= {reg_wdata[11:8], reg_wdata[3:0]};
        rsv_lo <= reg_wdata[6:4];
        rsv_hi <= reg_wdata[14:12];
        low_nibble_drive <= reg_wdata[`PORT_DIR_LO];
        high_nibble_drive <= reg_wdata[`PORT_DIR_HI];
      end
      aux_port_line_out <= port_out;
      aux_port_line_oe <= {{4{high_nibble_drive}}, {4{low_nibble_drive}}};
    end
  end

  assign ctrl_view = {27'h0, indicator_lamp_on, cal_pass, cal_running, rate_b_en, rate_a_en};

  // Read mux; unmapped reads zero
  always @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_CTRL: reg_rdata <= ctrl_view;
        `OFS_PORT: reg_rdata <= {16'h0000, high_nibble_drive, rsv_hi,
          (high_nibble_drive ? port_out[7:4] : port_in[7:4]),
          low_nibble_drive, rsv_lo,
          (low_nibble_drive ? port_out[3:0] : port_in[3:0])};
        `OFS_STATUS: reg_rdata <= {15'h0000, cal_done_rsp, 15'h0000, cal_done_sel};
        `OFS_RATE_A: reg_rdata <= {8'h00, sample_rate_divisor};
        `OFS_RATE_B: reg_rdata <= {8'h00, trigger_rate_divisor};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// [rate_dio_consts.vh]
// Register offsets, field positions, reset values and timing counts
`ifndef RATE_DIO_CONSTS_VH
`define RATE_DIO_CONSTS_VH
`define OFS_PORT 8'h04
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h30
`define OFS_RATE_A 8'h4C
`define OFS_RATE_B 8'h50
`define CTRL_RATE_A_EN 0
`define CTRL_RATE_B_EN 1
`define CTRL_AUTOCAL 2
`define CTRL_CAL_PASS 3
`define CTRL_LAMP 4
`define PORT_DIR_LO 7
`define PORT_DIR_HI 15
`define STAT_CAL_SEL 0
`define STAT_CAL_RSP 16
`define RATE_A_RESET 24'h000200
`define RATE_B_RESET 24'h003000
`define CAL_TYPICAL_MS 7000
`define CAL_MAX_MS 10000
`define CLK_KHZ 125000
`define CAL_CYCLES (`CAL_TYPICAL_MS * `CLK_KHZ)
`endif

// [rate_divider.v]
// One programmable rate generator emitting one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module rate_divider #(
  parameter WIDTH = 24
) (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Control
  input wire enable,
  input wire restart,
  input wire [WIDTH-1:0] divisor,
  // Output
  output reg tick
);
  reg [WIDTH-1:0] count;
  always @(posedge sys_clk) begin
    if (!resetn || !enable || restart) begin
      count <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end else if (count + 1'b1 >= divisor) begin
      count <= {WIDTH{1'b0}};
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [rate_ctrl_sva.sv]
// Assertion checker for the rate generator, port and calibration block
`timescale 1ns/1ns
`default_nettype none
module rate_ctrl_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Outputs
  input wire logic sample_clock_tick,
  input wire logic [7:0] aux_port_line_out,
  input wire logic [7:0] aux_port_line_oe,
  input wire logic cal_running,
  input wire logic indicator_lamp_on
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire port_wr = reg_wr && reg_addr == 8'h04;
  wire ctrl_wr = reg_wr && reg_addr == 8'h00;
  property p_tick; sample_clock_tick |=> !sample_clock_tick; endproperty
  a_tick: assert property (p_tick) else $error("tick too wide");
  property p_dir;
    port_wr |-> ##2 aux_port_line_oe == {{4{$past(reg_wdata[15], 2)}}, {4{$past(reg_wdata[7], 2)}}};
  endproperty
  a_dir: assert property (p_dir) else $error("port direction wrong");
  property p_out;
    port_wr |-> ##2 aux_port_line_out == {$past(reg_wdata[11:8], 2), $past(reg_wdata[3:0], 2)};
  endproperty
  a_out: assert property (p_out) else $error("port data wrong");
  property p_nib;
    aux_port_line_oe == {{4{aux_port_line_oe[4]}}, {4{aux_port_line_oe[0]}}};
  endproperty
  a_nib: assert property (p_nib) else $error("nibble split");
  property p_port_rd; reg_rd && reg_addr == 8'h04 |=> reg_rdata[31:16] == 16'h0; endproperty
  a_port_rd: assert property (p_port_rd) else $error("port upper bits");
  property p_rate_rd;
    reg_rd && (reg_addr == 8'h4C || reg_addr == 8'h50) |=> reg_rdata[31:24] == 8'h00;
  endproperty
  a_rate_rd: assert property (p_rate_rd) else $error("divisor upper byte");
  property p_lamp; ctrl_wr |=> indicator_lamp_on == $past(reg_wdata[4]); endproperty
  a_lamp: assert property (p_lamp) else $error("lamp wrong");
  property p_cal; ctrl_wr && reg_wdata[2] && !cal_running |=> cal_running; endproperty
  a_cal: assert property (p_cal) else $error("calibration not started");
  c_tick: cover property (sample_clock_tick);
  c_cal: cover property ($fell(cal_running));
  c_drive: cover property (port_wr ##2 aux_port_line_oe != 8'h00);
endmodule
bind rate_gen_dio_autocal_ctrl rate_ctrl_sva i_rate_ctrl_sva (.sys_clk(sys_clk),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_clock_tick(sample_clock_tick),
  .aux_port_line_out(aux_port_line_out), .aux_port_line_oe(aux_port_line_oe),
  .cal_running(cal_running), .indicator_lamp_on(indicator_lamp_on));
`default_nettype wire

// [rate_gen_dio_autocal_ctrl_tb.sv]
// Self-checking bench for the rate generator, port and calibration block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("Error %0t: got %h exp %h", $time, a, e); end end
module rate_gen_dio_autocal_ctrl_tb;
  logic sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, fail_in = 0;
  logic [7:0] reg_addr = 8'h00, pins = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  wire [31:0] rdata;
  wire [7:0] pout, poe;
  wire tick_a, tick_b, running, active, lamp;
  integer fail_count = 0, total_checks = 0, i, n;
  rate_gen_dio_autocal_ctrl #(.CAL_CYCLES(20)) i_rate_gen_dio_autocal_ctrl (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata),
    .sample_clock_tick(tick_a), .burst_trigger_tick(tick_b),
    .aux_port_line_in(pins), .aux_port_line_out(pout), .aux_port_line_oe(poe),
    .cal_engine_fail(fail_in), .cal_corr_valid(1'b0), .cal_corr_index(4'h0),
    .cal_corr_value(16'h0000), .cal_running(running), .analog_outputs_active(active),
    .indicator_lamp_on(lamp));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task results;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(negedge sys_clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge sys_clk) reg_wr = 0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(negedge sys_clk) {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge sys_clk) reg_rd = 0;
      `CHK(rdata, e)
    end
  endtask
  // Cycles from one tick to the next; bounded so a dead generator cannot hang
  task period(input integer b, input integer e);
    begin
      n = 0;
      while ((b ? tick_b : tick_a) !== 1'b1 && n < 99) begin @(negedge sys_clk); n++; end
      n = 1;
      @(negedge sys_clk);
      while ((b ? tick_b : tick_a) !== 1'b1 && n < 99) begin @(negedge sys_clk); n++; end
      `CHK(n, e)
    end
  endtask
  initial begin
    repeat (3) @(negedge sys_clk);
    resetn = 1;
    `CHK(lamp, 1'b1)
    `CHK(poe, 8'h00)
    rd(8'h4C, 32'h00000200);
    rd(8'h50, 32'h00003000);
    rd(8'h00, 32'h00000018);
    rd(8'h60, 32'h0); // unmapped
    $display("reset values done");
    wr(8'h4C, 32'hFFFFFFFF);
    rd(8'h4C, 32'h00FFFFFF);
    wr(8'h4C, 32'h5);
    wr(8'h50, 32'h7);
    n = 0;
    for (i = 0; i < 20; i++) begin @(negedge sys_clk); n += tick_a + tick_b; end
    `CHK(n, 0)
    wr(8'h00, 32'h11);
    period(0, 5);
    `CHK(tick_b, 1'b0)
    wr(8'h00, 32'h13);
    period(1, 7);
    wr(8'h4C, 32'h000000FA);
    rd(8'h4C, 32'h000000FA);
    $display("rate generators done");
    pins = 8'h5C;
    wr(8'h04, 32'h00008A03);
    repeat (5) @(negedge sys_clk);
    `CHK({poe, pout[7:4]}, 12'hF0A)
    rd(8'h04, 32'h00008A0C);
    wr(8'h04, 32'h00000085);
    repeat (5) @(negedge sys_clk);
    `CHK({poe, pout[3:0]}, 12'h0F5)
    rd(8'h04, 32'h00000585);
    $display("digital port done");
    wr(8'h30, 32'h1);
    for (i = 0; i < 3; i++) begin
      fail_in = (i == 1);
      wr(8'h00, 32'h14);
      n = 0;
      while (running === 1'b1 && n < 100) begin `CHK(active, 1'b1) n++; @(negedge sys_clk); end
      `CHK(running, 1'b0)
      rd(8'h00, (i == 1) ? 32'h10 : 32'h18);
      rd(8'h30, 32'h00010001);
      wr(8'h30, 32'h1);
      rd(8'h30, 32'h1);
    end
    $display("calibration done");
    wr(8'h00, 32'h0);
    `CHK(lamp, 1'b0)
    $display("lamp done");
    results();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
